// file: src/wpam_pkg.sv
// Shared constants and types for the write precompensation and address mark block
package wpam_pkg;
  // Pair register file
  localparam int         NUM_PAIRS    = 22;
  localparam int         IDX_W        = 5;
  localparam logic [3:0] PAIR_RESET   = 4'h0;
  localparam int         COARSE_HI    = 3;
  localparam int         COARSE_LO    = 2;
  localparam int         FINE_HI      = 1;
  localparam int         FINE_LO      = 0;
  // Pulse periods in code bits
  localparam logic [3:0] T_MIN        = 4'h2;
  localparam logic [3:0] T_CLAMP      = 4'h8;
  localparam int         TRAIL_SPAN   = 8;
  // Address mark as sent: lead one, 8T, 8T, 12T, 12T, 3T, 3T, 3T
  localparam int          AM_LEN      = 50;
  localparam logic [49:0] AM_PATTERN  = {1'h1, 8'h01, 8'h01, 12'h001, 12'h001, 9'h049};
  localparam logic [5:0]  AM_LAST     = 6'h31;
  // Address mark detection
  localparam logic [3:0] ZRUN_MAX       = 4'hF;
  localparam logic [3:0] SIX_ZEROS      = 4'h6;
  localparam logic [3:0] NINE_ZEROS     = 4'h9;
  localparam logic [3:0] HF_MIN         = 4'h2;
  localparam logic [3:0] HF_MAX         = 4'h4;
  localparam logic [1:0] HF_COUNT       = 2'h3;
  localparam logic [5:0] NINE_TIMEOUT_T = 6'h22;
  localparam logic [5:0] HF_TIMEOUT_T   = 6'h18;
  // Data path buffering
  localparam int         FIFO_DEPTH   = 4;
  localparam int         CLOCK_HZ     = 25000000;

  typedef enum logic [1:0] {
    DET_SIX,
    DET_NINE,
    DET_HF,
    DET_FOUND
  } wpam_det_t;
endpackage

// file: src/wpam_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module wpam_fifo #(
  parameter int W     = 1,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == (AW)'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= ptr_inc(wptr_r);
      end
      if (pop) begin
        rptr_r <= ptr_inc(rptr_r);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: src/wpam_pair_map.sv
// Maps a leading/trailing pulse period pair to a pair register index and sign
`timescale 1ns/1ps
`default_nettype none
module wpam_pair_map (
  input  wire logic [3:0] lead,
  input  wire logic [3:0] trail,
  output logic [4:0]      idx,
  output logic            neg,
  output logic            none
);
  logic [3:0] lo;
  logic [3:0] hi;

  // Row base for the longer period of the pair
  function automatic logic [4:0] row_base(input logic [3:0] h);
    unique case (h)
      4'h3:    return 5'h00;
      4'h4:    return 5'h02;
      4'h5:    return 5'h04;
      4'h6:    return 5'h08;
      4'h7:    return 5'h0C;
      default: return 5'h10;
    endcase
  endfunction

  always_comb begin
    lo   = (lead < trail) ? lead : trail;
    hi   = (lead < trail) ? trail : lead;
    neg  = (trail < lead);
    none = (lead == trail) && (lead != wpam_pkg::T_MIN);
    if (lead == wpam_pkg::T_MIN && trail == wpam_pkg::T_MIN) begin
      idx = 5'h01;
    end else if (lo == 4'h6 && hi == 4'h7) begin
      idx = 5'h07;
    end else begin
      idx = row_base(hi) + {1'b0, lo - wpam_pkg::T_MIN};
    end
  end
endmodule
`default_nettype wire

// file: src/wpam_top.sv
// Write precompensation selector with address mark insertion and detection
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Pair matrix; diagonal zero, mirrors opposite sign
// - 2T/2T pair has its own entry
// - Pair picks register, order gives the sign
// - 7T/8T and 8T/7T entries are applied
// - Periods above 8T looked up as 8T
// - Second of two adjacent ones becomes zero
// - Spacing to previous and next one decides
// - Coarse plus fine steps form the shift
// - Shift applied only with precompensation enabled
// - Ramp loop off: fine fields ignored
// - Detect starts with enable, one plus six zeros
// - Then one plus nine zeros, bounded window
// - Then three high-frequency intervals: mark found
// - Mark is 8T 8T 12T 12T 3T 3T 3T
// - Mark jammed into stream at exact position
// - 1T at mark start suppresses second one
// - High-frequency intervals written as 001
// - 2T to 4T count as high frequency
// - Timeouts 34T for nine zeros, 24T for HF
// - Output marks with falling edges, idle high
module wpam_top #(
  parameter int BIT_DIV = 1
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       write_gate,
  input  wire logic       address_mark_enable,
  input  wire logic       precomp_enable_bit,
  input  wire logic       ramp_loop_enable_bit,
  input  wire logic       enc_bit,
  input  wire logic       enc_valid,
  output logic            enc_ready,
  input  wire logic       rd_sync_data,
  input  wire logic       rd_sync_clk,
  input  wire logic       reg_wr_en,
  input  wire logic [4:0] reg_index,
  input  wire logic [3:0] reg_wdata,
  output logic [3:0]      reg_rdata,
  output logic            precomp_write_out,
  output logic [3:0]      precomp_shift,
  output logic            precomp_shift_neg,
  output logic            ramp_loop_power,
  output logic            am_writing,
  output logic            am_detected
);
  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  logic        rdclk_d_r;
  logic        ame_d_r;
  logic        wg_s;
  logic        ame_s;
  logic        rd_bit;
  logic        rd_en;
  logic [7:0]  div_r;
  logic        bit_en;
  logic        step;
  logic        fifo_valid;
  logic        fifo_bit;
  logic        src_bit;
  logic        clean_bit;
  logic        last_in_r;
  logic [8:0]  sr_r;
  logic [3:0]  lead_cnt_r;
  logic [3:0]  trail_w;
  logic [4:0]  map_idx;
  logic        map_neg;
  logic        map_none;
  logic [3:0]  sel_val;
  logic [3:0]  shift_nxt;
  logic        am_active_r;
  logic [5:0]  am_idx_r;
  logic [3:0]  pair_r [wpam_pkg::NUM_PAIRS];
  logic [3:0]  rdata_r;
  logic        wout_r;
  logic [3:0]  shift_r;
  logic        neg_r;
  logic        ramp_r;
  wpam_pkg::wpam_det_t det_r;
  logic [3:0]  zrun_r;
  logic [3:0]  zrun_nxt;
  logic [5:0]  tmr_r;
  logic [1:0]  hf_cnt_r;

  // Pins from outside the clock domain
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_r   <= 4'h0;
      sync2_r   <= 4'h0;
      rdclk_d_r <= 1'b0;
      ame_d_r   <= 1'b0;
    end else begin
      sync1_r   <= {write_gate, address_mark_enable, rd_sync_data, rd_sync_clk};
      sync2_r   <= sync1_r;
      rdclk_d_r <= sync2_r[0];
      ame_d_r   <= sync2_r[2];
    end
  end

  assign wg_s   = sync2_r[3];
  assign ame_s  = sync2_r[2];
  assign rd_bit = sync2_r[1];
  assign rd_en  = sync2_r[0] && !rdclk_d_r;

  // Code-bit rate enable
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_r <= 8'h00;
    end else if (div_r == 8'(BIT_DIV - 1)) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign bit_en = (div_r == 8'(BIT_DIV - 1));
  assign step   = bit_en && wg_s;

  // Encoded write data buffer; drained one bit per code-bit time
  wpam_fifo #(
    .W     (1),
    .DEPTH (wpam_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (enc_valid),
    .in_ready  (enc_ready),
    .in_data   (enc_bit),
    .out_valid (fifo_valid),
    .out_ready (step),
    .out_data  (fifo_bit)
  );

  // Mark bits replace stream bits; an underrun writes zeros
  assign src_bit   = am_active_r ? wpam_pkg::AM_PATTERN[6'(wpam_pkg::AM_LEN - 1) - am_idx_r]
                                 : (fifo_valid && fifo_bit);
  assign clean_bit = src_bit && !last_in_r;

  // Mark insertion on the rising enable, independent of the gap phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      am_active_r <= 1'b0;
      am_idx_r    <= 6'h00;
    end else if (!wg_s) begin
      am_active_r <= 1'b0;
      am_idx_r    <= 6'h00;
    end else if (ame_s && !ame_d_r && !am_active_r) begin
      am_active_r <= 1'b1;
      am_idx_r    <= 6'h00;
    end else if (step && am_active_r) begin
      am_active_r <= (am_idx_r != wpam_pkg::AM_LAST);
      am_idx_r    <= am_idx_r + 6'h01;
    end
  end

  // Delay line gives the trailing spacing before the bit leaves
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last_in_r  <= 1'b0;
      sr_r       <= 9'h000;
      lead_cnt_r <= wpam_pkg::T_CLAMP;
    end else if (!wg_s) begin
      last_in_r  <= 1'b0;
      sr_r       <= 9'h000;
      lead_cnt_r <= wpam_pkg::T_CLAMP;
    end else if (step) begin
      last_in_r <= clean_bit;
      sr_r      <= {sr_r[7:0], clean_bit};
      if (sr_r[8]) begin
        lead_cnt_r <= 4'h1;
      end else if (lead_cnt_r != wpam_pkg::T_CLAMP) begin
        lead_cnt_r <= lead_cnt_r + 4'h1;
      end
    end
  end

  // Distance to the next one; none within reach counts as 8T
  function automatic logic [3:0] trail_dist(input logic [7:0] v);
    logic [3:0] d;
    d = wpam_pkg::T_CLAMP;
    for (int i = 0; i < wpam_pkg::TRAIL_SPAN; i++) begin
      if (v[i]) begin
        d = 4'(wpam_pkg::TRAIL_SPAN - i);
      end
    end
    return d;
  endfunction

  assign trail_w = trail_dist(sr_r[7:0]);

  wpam_pair_map u_map (
    .lead  (lead_cnt_r),
    .trail (trail_w),
    .idx   (map_idx),
    .neg   (map_neg),
    .none  (map_none)
  );

  assign sel_val = (map_idx < 5'(wpam_pkg::NUM_PAIRS)) ? pair_r[map_idx] : 4'h0;

  always_comb begin
    shift_nxt = 4'h0;
    if (precomp_enable_bit && !map_none) begin
      shift_nxt[wpam_pkg::COARSE_HI:wpam_pkg::COARSE_LO] =
        sel_val[wpam_pkg::COARSE_HI:wpam_pkg::COARSE_LO];
      if (ramp_r) begin
        shift_nxt[wpam_pkg::FINE_HI:wpam_pkg::FINE_LO] =
          sel_val[wpam_pkg::FINE_HI:wpam_pkg::FINE_LO];
      end
    end
  end

  // Output stage: each one leaves as a low code-bit time
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wout_r  <= 1'b1;
      shift_r <= 4'h0;
      neg_r   <= 1'b0;
    end else if (!wg_s) begin
      wout_r  <= 1'b1;
      shift_r <= 4'h0;
      neg_r   <= 1'b0;
    end else if (step) begin
      wout_r  <= !sr_r[8];
      shift_r <= sr_r[8] ? shift_nxt : 4'h0;
      neg_r   <= sr_r[8] && map_neg && (shift_nxt != 4'h0);
    end
  end

  // Ramp loop power follows its enable; lock time is the host's concern
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ramp_r <= 1'b0;
    end else begin
      ramp_r <= ramp_loop_enable_bit;
    end
  end

  // Pair registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < wpam_pkg::NUM_PAIRS; i++) begin
        pair_r[i] <= wpam_pkg::PAIR_RESET;
      end
      rdata_r <= 4'h0;
    end else begin
      if (reg_wr_en && reg_index < 5'(wpam_pkg::NUM_PAIRS)) begin
        pair_r[reg_index] <= reg_wdata;
      end
      rdata_r <= (reg_index < 5'(wpam_pkg::NUM_PAIRS)) ? pair_r[reg_index] : 4'h0;
    end
  end

  // Read-side zero run length since the last one
  assign zrun_nxt = rd_bit ? 4'h0 :
                    (zrun_r == wpam_pkg::ZRUN_MAX) ? zrun_r : zrun_r + 4'h1;

  function automatic logic is_hf(input logic [3:0] z);
    return ((z + 4'h1) >= wpam_pkg::HF_MIN) && ((z + 4'h1) <= wpam_pkg::HF_MAX);
  endfunction

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      zrun_r <= wpam_pkg::ZRUN_MAX;
    end else if (rd_en) begin
      zrun_r <= zrun_nxt;
    end
  end

  // Three-step mark search
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      det_r    <= wpam_pkg::DET_SIX;
      tmr_r    <= 6'h00;
      hf_cnt_r <= 2'h0;
    end else if (!ame_s) begin
      det_r    <= wpam_pkg::DET_SIX;
      tmr_r    <= 6'h00;
      hf_cnt_r <= 2'h0;
    end else if (rd_en) begin
      unique case (det_r)
        wpam_pkg::DET_SIX: begin
          if (!rd_bit && zrun_nxt == wpam_pkg::SIX_ZEROS) begin
            det_r <= wpam_pkg::DET_NINE;
            tmr_r <= 6'h00;
          end
        end
        wpam_pkg::DET_NINE: begin
          if (!rd_bit && zrun_nxt == wpam_pkg::NINE_ZEROS) begin
            det_r    <= wpam_pkg::DET_HF;
            tmr_r    <= 6'h00;
            hf_cnt_r <= 2'h0;
          end else if (tmr_r == wpam_pkg::NINE_TIMEOUT_T) begin
            det_r <= wpam_pkg::DET_SIX;
          end else begin
            tmr_r <= tmr_r + 6'h01;
          end
        end
        wpam_pkg::DET_HF: begin
          if (rd_bit && is_hf(zrun_r) && hf_cnt_r == wpam_pkg::HF_COUNT - 2'h1) begin
            det_r <= wpam_pkg::DET_FOUND;
          end else if (tmr_r == wpam_pkg::HF_TIMEOUT_T) begin
            det_r <= wpam_pkg::DET_SIX;
          end else begin
            tmr_r <= tmr_r + 6'h01;
            if (rd_bit) begin
              hf_cnt_r <= is_hf(zrun_r) ? hf_cnt_r + 2'h1 : 2'h0;
            end
          end
        end
        wpam_pkg::DET_FOUND: begin
          det_r <= wpam_pkg::DET_FOUND;
        end
      endcase
    end
  end

  assign reg_rdata         = rdata_r;
  assign precomp_write_out = wout_r;
  assign precomp_shift     = shift_r;
  assign precomp_shift_neg = neg_r;
  assign ramp_loop_power   = ramp_r;
  assign am_writing        = am_active_r;
  assign am_detected       = (det_r == wpam_pkg::DET_FOUND);

  a_idle_high: assert property (@(posedge clock) disable iff (!rstn)
    !wg_s |=> wout_r) else $error("write output not high while gate idle");
  a_no_adjacent: assert property (@(posedge clock) disable iff (!rstn)
    !(sr_r[8] && sr_r[7])) else $error("adjacent ones reached output");
  a_diag_zero: assert property (@(posedge clock) disable iff (!rstn)
    step && sr_r[8] && lead_cnt_r == trail_w && lead_cnt_r != wpam_pkg::T_MIN
    |=> shift_r == 4'h0) else $error("diagonal pair got a shift");
  a_disable_zero: assert property (@(posedge clock) disable iff (!rstn)
    step && !precomp_enable_bit |=> shift_r == 4'h0) else $error("shift while disabled");
  a_fine_ignored: assert property (@(posedge clock) disable iff (!rstn)
    step && !ramp_r |=> shift_r[1:0] == 2'h0) else $error("fine used with ramp off");
  a_sign_order: assert property (@(posedge clock) disable iff (!rstn)
    step && sr_r[8] && trail_w < lead_cnt_r && shift_nxt != 4'h0 |=> neg_r)
    else $error("sign does not follow pair order");
  a_lead_clamp: assert property (@(posedge clock) disable iff (!rstn)
    lead_cnt_r <= wpam_pkg::T_CLAMP && lead_cnt_r != 4'h0)
    else $error("leading period outside range");
  a_nine_bound: assert property (@(posedge clock) disable iff (!rstn)
    det_r == wpam_pkg::DET_NINE |-> tmr_r <= wpam_pkg::NINE_TIMEOUT_T)
    else $error("nine-zero wait overran");
  a_found_path: assert property (@(posedge clock) disable iff (!rstn)
    $rose(am_detected) |-> $past(det_r) == wpam_pkg::DET_HF && $past(rd_bit))
    else $error("mark found outside HF step");
  a_enable_reset: assert property (@(posedge clock) disable iff (!rstn)
    !ame_s |=> det_r == wpam_pkg::DET_SIX) else $error("search active without enable");

  c_mark_found: cover property (@(posedge clock) disable iff (!rstn) $rose(am_detected));
  c_mark_written: cover property (@(posedge clock) disable iff (!rstn) $fell(am_writing));
  c_neg_shift: cover property (@(posedge clock) disable iff (!rstn) step && neg_r);
  c_timeout: cover property (@(posedge clock) disable iff (!rstn)
    det_r == wpam_pkg::DET_HF ##1 det_r == wpam_pkg::DET_SIX);
endmodule
`default_nettype wire

// file: tb/wpam_host_model.sv
// Controller-side model: encoded write bits and synchronized read bits
`timescale 1ns/1ps
`default_nettype none
module wpam_host_model (
  input  wire logic clock,
  input  wire logic enc_ready,
  output logic      enc_bit,
  output logic      enc_valid,
  output logic      rd_sync_clk,
  output logic      rd_sync_data
);
  logic busy;

  initial begin
    enc_bit = 1'h0;
    enc_valid = 1'h0;
    rd_sync_clk = 1'h0;
    rd_sync_data = 1'h0;
    busy = 1'h0;
  end

  // Idle read line wanders so a stale level never looks like data
  always @(negedge clock) begin
    if (!busy) rd_sync_data <= ~rd_sync_data;
  end

  task automatic push_enc(input logic [127:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      enc_valid = 1'h1;
      enc_bit = b[i];
      while (enc_ready !== 1'h1) @(negedge clock);
      @(posedge clock);
    end
    @(negedge clock);
    enc_valid = 1'h0;
  endtask

  // Two cycles low, two high per bit; clock stands low between frames
  task automatic send_read(input logic [127:0] b, input int n);
    busy = 1'h1;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      rd_sync_data = b[i];
      rd_sync_clk = 1'h0;
      @(negedge clock);
      @(negedge clock);
      rd_sync_clk = 1'h1;
      @(negedge clock);
    end
    @(negedge clock);
    rd_sync_clk = 1'h0;
    busy = 1'h0;
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the precompensation and address mark block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int BD = 4;
  logic       clock, rstn, write_gate, address_mark_enable;
  logic       precomp_enable_bit, ramp_loop_enable_bit, enc_bit, enc_valid, enc_ready;
  logic       rd_sync_data, rd_sync_clk, reg_wr_en, precomp_write_out, precomp_shift_neg;
  logic       ramp_loop_power, am_writing, am_detected, prev_out, saw_amw;
  logic [4:0] reg_index;
  logic [3:0] reg_wdata, reg_rdata, precomp_shift;
  logic [3:0] regv [22];
  logic [4:0] fall_s[$], exp_s[$];
  int         fall_t[$], exp_iv[$];
  logic [127:0] bits;
  int         nb, cyc, n_fail, samples_checked;

  wpam_top #(.BIT_DIV(BD)) wpam_top_i (
    .clock(clock), .rstn(rstn), .write_gate(write_gate),
    .address_mark_enable(address_mark_enable), .precomp_enable_bit(precomp_enable_bit),
    .ramp_loop_enable_bit(ramp_loop_enable_bit), .enc_bit(enc_bit), .enc_valid(enc_valid),
    .enc_ready(enc_ready), .rd_sync_data(rd_sync_data), .rd_sync_clk(rd_sync_clk),
    .reg_wr_en(reg_wr_en), .reg_index(reg_index), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .precomp_write_out(precomp_write_out),
    .precomp_shift(precomp_shift), .precomp_shift_neg(precomp_shift_neg),
    .ramp_loop_power(ramp_loop_power), .am_writing(am_writing), .am_detected(am_detected));

  wpam_host_model wpam_host_model_i (
    .clock(clock), .enc_ready(enc_ready), .enc_bit(enc_bit), .enc_valid(enc_valid),
    .rd_sync_clk(rd_sync_clk), .rd_sync_data(rd_sync_data));

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) cyc <= cyc + 1;

  // Every falling edge of the write output, with its shift
  always @(negedge clock) begin
    prev_out <= precomp_write_out;
    if (am_writing === 1'h1) saw_amw <= 1'h1;
    if (prev_out === 1'h1 && precomp_write_out === 1'h0) begin
      fall_t.push_back(cyc);
      fall_s.push_back({precomp_shift_neg, precomp_shift});
    end
  end

  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic reg_wr(input logic [4:0] i, input logic [3:0] d);
    @(negedge clock);
    reg_wr_en = 1'h1;
    reg_index = i;
    reg_wdata = d;
    @(negedge clock);
    reg_wr_en = 1'h0;
  endtask

  task automatic reg_chk(input logic [4:0] i, input logic [3:0] e);
    @(negedge clock);
    reg_index = i;
    repeat (2) @(negedge clock);
    chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
  endtask

  // One bit at lead0, then a one after each interval, then trailing zeros
  task automatic build(input int iv[$], input int lead0);
    bits = '0;
    nb = lead0;
    bits[nb] = 1'h1;
    foreach (iv[k]) begin
      nb += iv[k];
      bits[nb] = 1'h1;
    end
    nb += 11;
  endtask

  function automatic logic [4:0] pair_val(input int l, input int t);
    int s, b, ix;
    logic [3:0] v;
    s = (l < t) ? l : t;
    b = (l < t) ? t : l;
    if (s == b && s != 2) return 5'h00;
    if (s == 2 && b == 2) ix = 1;
    else if (s == 6 && b == 7) ix = 7;
    else if (b == 3) ix = 0;
    else if (b == 4) ix = s;
    else ix = (b - 4) * 4 + s - 2;
    v = regv[ix];
    if (ramp_loop_enable_bit !== 1'h1) v[1:0] = 2'h0;
    if (precomp_enable_bit !== 1'h1) v = 4'h0;
    return {(v != 4'h0) && (t < l), v};
  endfunction

  task automatic expect_run();
    int last, t;
    logic [127:0] p;
    p = bits;
    for (int i = 1; i < 128; i++) if (p[i] && p[i-1]) p[i] = 1'h0;
    last = -100;
    exp_iv.delete();
    exp_s.delete();
    for (int i = 0; i < nb; i++) if (p[i]) begin
      t = 8;
      for (int j = 8; j >= 1; j--) if (i + j < 128 && p[i+j]) t = j;
      exp_iv.push_back(i - last);
      exp_s.push_back(pair_val((i - last > 8) ? 8 : i - last, t));
      last = i;
    end
  endtask

  task automatic compare_run(input string what);
    chk({what, " pulses"}, 8'(exp_s.size()), 8'(fall_t.size()));
    foreach (exp_s[k]) if (k < fall_t.size()) begin
      chk({what, " shift"}, {3'h0, exp_s[k]}, {3'h0, fall_s[k]});
      if (k > 0) chk({what, " interval"}, 8'(exp_iv[k]), 8'((fall_t[k] - fall_t[k-1]) / BD));
    end
    fall_t.delete();
    fall_s.delete();
  endtask

  task automatic write_pass(input logic en, input logic rmp);
    @(negedge clock);
    precomp_enable_bit = en;
    ramp_loop_enable_bit = rmp;
    repeat (40) @(negedge clock);
    chk("ramp_loop_power", {7'h0, rmp}, {7'h0, ramp_loop_power});
    build('{2, 2, 3, 2, 4, 3, 5, 8, 7, 8, 6, 7, 1, 3, 12, 2, 6, 5}, 8);
    expect_run();
    write_gate = 1'h1;
    wpam_host_model_i.push_enc(bits, nb);
    repeat (20 * BD) @(negedge clock);
    write_gate = 1'h0;
    repeat (4) @(negedge clock);
    chk("idle level", 8'h01, {7'h0, precomp_write_out});
    compare_run("stream");
  endtask

  task automatic detect(input int iv[$], input logic ena, input logic e);
    build(iv, 0);
    @(negedge clock);
    address_mark_enable = ena;
    repeat (4) @(negedge clock);
    wpam_host_model_i.send_read(bits, nb);
    repeat (8) @(negedge clock);
    chk("am_detected", {7'h0, e}, {7'h0, am_detected});
    address_mark_enable = 1'h0;
    repeat (6) @(negedge clock);
    chk("am_detected cleared", 8'h00, {7'h0, am_detected});
  endtask

  initial begin
    #1200000;
    n_fail++;
    finish_test();
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    rstn = 1'h0;
    write_gate = 1'h0;
    address_mark_enable = 1'h0;
    precomp_enable_bit = 1'h0;
    ramp_loop_enable_bit = 1'h0;
    reg_wr_en = 1'h0;
    reg_index = 5'h00;
    reg_wdata = 4'h0;
    prev_out = 1'h1;
    saw_amw = 1'h0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rstn = 1'h1;
    chk("idle level", 8'h01, {7'h0, precomp_write_out});
    reg_chk(5'h15, 4'h0);
    for (int i = 0; i < 22; i++) begin
      regv[i] = 4'((i % 15) + 1);
      reg_wr(5'(i), regv[i]);
    end
    reg_wr(5'h16, 4'hF);
    for (int i = 0; i < 22; i++) reg_chk(5'(i), regv[i]);
    reg_chk(5'h16, 4'h0);
    write_pass(1'h1, 1'h0);
    write_pass(1'h0, 1'h1);
    write_pass(1'h1, 1'h1);
    // Mark inserted into an idle stream: only its own ones appear
    build('{8, 8, 12, 12, 3, 3, 3}, 20);
    expect_run();
    @(negedge clock);
    write_gate = 1'h1;
    repeat (20) @(negedge clock);
    address_mark_enable = 1'h1;
    repeat (80 * BD) @(negedge clock);
    address_mark_enable = 1'h0;
    write_gate = 1'h0;
    repeat (4) @(negedge clock);
    chk("am_writing seen", 8'h01, {7'h0, saw_amw});
    compare_run("mark");
    detect('{5, 5, 5, 5, 5, 5, 5, 5, 7, 10, 2, 4, 3}, 1'h1, 1'h1);
    detect('{5, 5, 5, 5, 5, 5, 5, 5, 7, 10, 2, 4, 3}, 1'h0, 1'h0);
    detect('{5, 5, 7, 10, 5, 5, 5, 5, 5, 5, 3, 3, 3}, 1'h1, 1'h0);
    // Late high-frequency run times out, then a fresh search finds the mark
    detect('{5, 5, 7, 10, 5, 5, 5, 5, 5, 5, 3, 3, 3, 5, 5, 7, 10, 2, 4, 3}, 1'h1, 1'h1);
    finish_test();
  end
endmodule
`default_nettype wire
